//--- rtl/wdtc_pkg.sv
// Package of constants and types for the watchdog timer control block.
package wdtc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] WDTC_CTRL_OFF   = 8'hd8;
    localparam logic [7:0] WDTC_IRQEN_OFF  = 8'hd9;
    localparam logic [7:0] WDTC_CNT_OFF    = 8'hda;

    // ==========================================================
    // Control and interrupt enable register fields
    localparam int WDTC_SEL_HI_BIT  = 7;
    localparam int WDTC_SEL_LO_BIT  = 6;
    localparam int WDTC_IRQF_BIT    = 3;
    localparam int WDTC_RSTF_BIT    = 2;
    localparam int WDTC_RSTEN_BIT   = 1;
    localparam int WDTC_RESTART_BIT = 0;
    localparam int WDTC_IRQEN_BIT   = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] WDTC_CTRL_RST  = 8'hd0;
    localparam logic [1:0] WDTC_SEL_RST   = 2'h3;
    localparam logic [1:0] WDTC_RSV_RST   = 2'h1;

    // ==========================================================
    // Time-out counts
    localparam int         WDTC_CNT_W      = 22;
    localparam int         WDTC_BASE_SHIFT = 16;
    localparam logic [5:0] WDTC_MULT_M0    = 6'h01;
    localparam logic [5:0] WDTC_MULT_M1    = 6'h04;
    localparam logic [5:0] WDTC_MULT_M2    = 6'h10;
    localparam logic [5:0] WDTC_MULT_M3    = 6'h20;
    localparam int         WDTC_RST_GAP    = 256;
    localparam int         WDTC_RST_DELAY  = 512;
    localparam int         WDTC_DLY_W      = 10;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        WDTC_ST_RUN  = 3'b001,
        WDTC_ST_WAIT = 3'b010,
        WDTC_ST_DONE = 3'b100
    } wdtc_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdtc_bus_t;

endpackage : wdtc_pkg

//--- rtl/wdtc_tmo_dec.sv
// Period select decoder giving interrupt and reset time-out counts.
`timescale 1ns/1ns
module wdtc_tmo_dec
    import wdtc_pkg::*;
(
    input  wire logic [1:0]            sel_i,
    output logic      [WDTC_CNT_W-1:0] irq_cnt_o,
    output logic      [WDTC_CNT_W-1:0] rst_cnt_o
);

    logic [5:0] mult;

    // ==========================================================
    // Decode
    always_comb begin
        unique case (sel_i)
            2'h0: mult = WDTC_MULT_M0;
            2'h1: mult = WDTC_MULT_M1;
            2'h2: mult = WDTC_MULT_M2;
            2'h3: mult = WDTC_MULT_M3;
        endcase
        irq_cnt_o = {mult, 16'h0000} - WDTC_CNT_W'(1);
        rst_cnt_o = WDTC_CNT_W'({mult, 16'h0000}) + WDTC_CNT_W'(WDTC_RST_GAP - 1);
    end

endmodule : wdtc_tmo_dec

//--- rtl/wdtc_top.sv
// Watchdog timer with control register, interrupt and device reset request.
//
// Contract
// - The period select chooses 1, 4, 16 or 32 times 2^16 clocks to the interrupt, the count wrapping to zero 256 later.
// - With reset enabled, a time-out raises the reset 512 clocks after the flag unless restarted.
// - Every time-out sets the interrupt flag; the interrupt line needs the interrupt enable.
// - The interrupt flag stays set until software clears it and keeps requesting meanwhile.
// - Software writing one to the interrupt flag requests an interrupt when enabled.
// - A watchdog reset sets the reset flag, which software must clear.
// - Software writing one to the reset flag only stores it and causes no reset.
// - With reset disabled, time-outs leave the reset flag alone.
// - The reset enable permits or blocks the device reset while the counter runs on.
// - The reset enable has no effect on the interrupt.
// - Writing one to the restart bit zeroes the count and the bit reads back zero.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
module wdtc_top
    import wdtc_pkg::*;
#(
    parameter int CNT_W = WDTC_CNT_W
)(
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            irq_o,
    output logic            dev_rst_o
);
    import wdtc_pkg::*;

    wdtc_bus_t              bus;
    logic [1:0]             sel_reg, sel_next;
    logic [1:0]             rsv_reg, rsv_next;
    logic                   irqf_reg, irqf_next;
    logic                   rstf_reg, rstf_next;
    logic                   rsten_reg, rsten_next;
    logic                   irqen_reg, irqen_next;
    logic [CNT_W-1:0]       cnt_reg, cnt_next;
    logic [WDTC_DLY_W-1:0]  dly_reg, dly_next;
    wdtc_state_t            st_reg, st_next;
    logic [7:0]             rdata_reg, rdata_next;
    logic                   irq_reg, irq_next;
    logic                   drst_reg, drst_next;
    logic [CNT_W-1:0]       irq_cnt;
    logic [CNT_W-1:0]       rst_cnt;
    logic                   ctrl_wr;
    logic                   restart;
    logic                   tmo_irq;
    logic                   tmo_rst;
    logic                   fire;

    assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    // ==========================================================
    // Time-out decoder
    wdtc_tmo_dec u_dec (
        .sel_i     (sel_reg),
        .irq_cnt_o (irq_cnt),
        .rst_cnt_o (rst_cnt)
    );

    assign ctrl_wr = bus.wr && (bus.addr == WDTC_CTRL_OFF);
    assign restart = ctrl_wr && bus.wdata[WDTC_RESTART_BIT];
    assign tmo_irq = (cnt_reg == irq_cnt);
    assign tmo_rst = (cnt_reg == rst_cnt);

    // ==========================================================
    // Counter and reset sequencer
    always_comb begin
        cnt_next = cnt_reg + CNT_W'(1);
        dly_next = dly_reg;
        st_next  = st_reg;
        fire     = 1'b0;
        if (restart) begin
            cnt_next = '0;
            dly_next = '0;
            st_next  = WDTC_ST_RUN;
        end else begin
            if (tmo_rst) begin
                cnt_next = '0;
            end
            unique case (st_reg)
                WDTC_ST_RUN: begin
                    if (tmo_irq && rsten_reg) begin
                        st_next  = WDTC_ST_WAIT;
                        dly_next = '0;
                    end
                end
                WDTC_ST_WAIT: begin
                    dly_next = dly_reg + WDTC_DLY_W'(1);
                    if (!rsten_reg) begin
                        st_next = WDTC_ST_RUN;
                    end else if (dly_reg == WDTC_DLY_W'(WDTC_RST_DELAY - 1)) begin
                        st_next = WDTC_ST_DONE;
                        fire    = 1'b1;
                    end
                end
                WDTC_ST_DONE: begin
                    st_next = WDTC_ST_RUN;
                end
                default: begin
                    st_next = WDTC_ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            dly_reg <= '0;
            st_reg  <= WDTC_ST_RUN;
        end else begin
            cnt_reg <= cnt_next;
            dly_reg <= dly_next;
            st_reg  <= st_next;
        end
    end

    // ==========================================================
    // Registers, flags and outputs
    always_comb begin
        sel_next   = sel_reg;
        rsv_next   = rsv_reg;
        irqf_next  = irqf_reg;
        rstf_next  = rstf_reg;
        rsten_next = rsten_reg;
        irqen_next = irqen_reg;
        if (ctrl_wr) begin
            sel_next   = {bus.wdata[WDTC_SEL_HI_BIT], bus.wdata[WDTC_SEL_LO_BIT]};
            rsv_next   = bus.wdata[5:4];
            irqf_next  = bus.wdata[WDTC_IRQF_BIT];
            rstf_next  = bus.wdata[WDTC_RSTF_BIT];
            rsten_next = bus.wdata[WDTC_RSTEN_BIT];
        end
        if (bus.wr && (bus.addr == WDTC_IRQEN_OFF)) begin
            irqen_next = bus.wdata[WDTC_IRQEN_BIT];
        end
        if (tmo_irq) begin
            irqf_next = 1'b1;
        end
        if (fire && rsten_reg) begin
            rstf_next = 1'b1;
        end
        irq_next  = irqf_next && irqen_next;
        drst_next = fire;
        rdata_next = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                WDTC_CTRL_OFF:  rdata_next = {sel_reg, rsv_reg, irqf_reg, rstf_reg,
                                              rsten_reg, 1'b0};
                WDTC_IRQEN_OFF: rdata_next = {7'h00, irqen_reg};
                WDTC_CNT_OFF:   rdata_next = cnt_reg[CNT_W-1:CNT_W-8];
                default:        rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_reg   <= WDTC_SEL_RST;
            rsv_reg   <= WDTC_RSV_RST;
            irqf_reg  <= 1'b0;
            rstf_reg  <= 1'b0;
            rsten_reg <= 1'b0;
            irqen_reg <= 1'b0;
            irq_reg   <= 1'b0;
            drst_reg  <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            sel_reg   <= sel_next;
            rsv_reg   <= rsv_next;
            irqf_reg  <= irqf_next;
            rstf_reg  <= rstf_next;
            rsten_reg <= rsten_next;
            irqen_reg <= irqen_next;
            irq_reg   <= irq_next;
            drst_reg  <= drst_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o   = rdata_reg;
    assign irq_o     = irq_reg;
    assign dev_rst_o = drst_reg;

endmodule : wdtc_top

//--- tb/wdtc_top_props.sv
// Port checks for the watchdog timer control block.
`timescale 1ns/1ns
module wdtc_top_props
    import wdtc_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       irq_o,
    input wire logic       dev_rst_o
);
    // ====
    // Cycles since the last restart write, saturating, and the written reset enable.
    logic        ctl_wr;
    logic [19:0] since_reg;
    logic [19:0] since_next;
    logic        en_reg;
    logic        en_next;
    assign ctl_wr = wr_i && addr_i == WDTC_CTRL_OFF;
    always_comb begin
        en_next    = ctl_wr ? wdata_i[WDTC_RSTEN_BIT] : en_reg;
        since_next = (since_reg == 20'hfffff) ? since_reg : since_reg + 20'h1;
        if (ctl_wr && wdata_i[WDTC_RESTART_BIT]) begin
            since_next = 20'h0;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_reg <= 20'h0;
            en_reg    <= 1'b0;
        end else begin
            since_reg <= since_next;
            en_reg    <= en_next;
        end
    end
    // ====
    // Assertions.
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_rst_pulse: assert property (dev_rst_o |=> !dev_rst_o)
        else $error("device reset longer than one cycle");
    chk_rst_delay: assert property ($rose(dev_rst_o) |-> since_reg >= 20'h10200)
        else $error("device reset too early");
    chk_flag_wr_quiet: assert property (ctl_wr && wdata_i[2] && !wdata_i[1] |-> ##2 (!dev_rst_o)[*4])
        else $error("reset flag write caused a reset");
    chk_restart_quiet: assert property (ctl_wr && wdata_i[0] |-> ##2 (!dev_rst_o)[*8])
        else $error("reset soon after restart");
    chk_strobe_zero: assert property ($past(rd_i) && $past(addr_i) == WDTC_CTRL_OFF |-> !rdata_o[0])
        else $error("restart bit reads one");
    chk_irq_cause: assert property ($rose(irq_o) |-> $past(wr_i) || since_reg >= 20'h10000)
        else $error("interrupt without cause");
    chk_irq_hold: assert property ($fell(irq_o) |-> $past(wr_i))
        else $error("interrupt dropped without write");
    chk_rst_enabled: assert property ($rose(dev_rst_o) |-> $past(en_reg))
        else $error("device reset while reset disabled");
    chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    cov_dev_rst: cover property (dev_rst_o);
    cov_irq_rise: cover property ($rose(irq_o));
    cov_irq_fall: cover property ($fell(irq_o));
endmodule : wdtc_top_props

bind wdtc_top wdtc_top_props u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .dev_rst_o(dev_rst_o));

//--- tb/wdtc_top_tb.sv
// Self-checking testbench for the watchdog timer control block.
`timescale 1ns/1ns
module wdtc_top_tb;
    import wdtc_pkg::*;
    logic       core_clk_i = 1'b0;
    logic       rst_n_i    = 1'b0;
    logic [7:0] addr_i     = 8'h00;
    logic [7:0] wdata_i    = 8'h00;
    logic       wr_i       = 1'b0;
    logic       rd_i       = 1'b0;
    logic [7:0] rdata_o;
    logic       irq_o;
    logic       dev_rst_o;
    int         fails      = 0;
    int         checked    = 0;
    int         n;

    always #50 core_clk_i = ~core_clk_i;

    wdtc_top DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .dev_rst_o(dev_rst_o));

    // ====
    // Shared tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1 check({24'h0, rdata_o}, {24'h0, exp});
    endtask : reg_rd
    task automatic irq_is(input logic exp);
        @(posedge core_clk_i);
        #1 check({31'h0, irq_o}, {31'h0, exp});
    endtask : irq_is
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // ====
    // Scenarios.
    task automatic t_reset_values;
        reg_rd(WDTC_CTRL_OFF, WDTC_CTRL_RST);
        reg_rd(WDTC_IRQEN_OFF, 8'h00);
        reg_rd(8'h00, 8'h00);
    endtask : t_reset_values
    task automatic t_soft_irq;
        reg_wr(WDTC_IRQEN_OFF, 8'h01);
        reg_wr(WDTC_CTRL_OFF, 8'h18);
        irq_is(1'b1);
        reg_rd(WDTC_CTRL_OFF, 8'h18);
        reg_wr(WDTC_IRQEN_OFF, 8'h00);
        irq_is(1'b0);
        reg_wr(WDTC_IRQEN_OFF, 8'h01);
        irq_is(1'b1);
        reg_wr(WDTC_CTRL_OFF, 8'h10);
        irq_is(1'b0);
    endtask : t_soft_irq
    task automatic t_flag_write;
        reg_wr(WDTC_CTRL_OFF, 8'h14);
        reg_rd(WDTC_CTRL_OFF, 8'h14);
        n = 0;
        repeat (600) begin
            @(posedge core_clk_i);
            #1 n += (dev_rst_o !== 1'b0);
        end
        check(n, 32'h0);
        reg_wr(WDTC_CTRL_OFF, 8'h10);
    endtask : t_flag_write
    task automatic t_timeout;
        reg_wr(WDTC_CTRL_OFF, 8'h13);
        repeat (20000) @(posedge core_clk_i);
        reg_rd(WDTC_CNT_OFF, 8'h01);
        reg_wr(WDTC_CTRL_OFF, 8'h13);
        n = 0;
        while (irq_o !== 1'b1 && n < 70000) begin
            @(posedge core_clk_i);
            #1 n++;
        end
        check(n, 32'(WDTC_MULT_M0) << WDTC_BASE_SHIFT);
        n = 0;
        while (dev_rst_o !== 1'b1 && n < 600) begin
            @(posedge core_clk_i);
            #1 n++;
        end
        check(n, 32'(WDTC_RST_DELAY));
        reg_rd(WDTC_CTRL_OFF, 8'h1e);
        reg_wr(WDTC_CTRL_OFF, 8'h10);
        reg_rd(WDTC_CTRL_OFF, 8'h10);
    endtask : t_timeout

    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_reset_values();
        t_soft_irq();
        t_flag_write();
        t_timeout();
        conclude();
    end
    initial begin
        repeat (99000) @(posedge core_clk_i);
        fails++;
        conclude();
    end
endmodule : wdtc_top_tb
